// file: hdl/sgp_pkg.sv
// Purpose: shared constants and types for the six-pin general purpose port
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   byte offsets of the register map, reset values and pad carrier
package sgp_pkg;

    localparam int SGP_PINS = 6;
    localparam int SGP_AW = 8;
    localparam int SGP_SYNC_STAGES = 2;

    // register byte offsets
    localparam logic [SGP_AW-1:0] SGP_OFF_PIN_VALUE = 8'h00;
    localparam logic [SGP_AW-1:0] SGP_OFF_OUTPUT_LATCH = 8'h04;
    localparam logic [SGP_AW-1:0] SGP_OFF_DIRECTION = 8'h08;
    localparam logic [SGP_AW-1:0] SGP_OFF_ANALOG_SELECT = 8'h0c;
    localparam logic [SGP_AW-1:0] SGP_OFF_OPEN_DRAIN = 8'h10;
    localparam logic [SGP_AW-1:0] SGP_OFF_SLEW_LIMIT = 8'h14;

    // values after reset
    localparam logic [SGP_PINS-1:0] SGP_RST_LATCH = 6'h00;
    localparam logic [SGP_PINS-1:0] SGP_RST_DIRECTION = 6'h3f;
    localparam logic [SGP_PINS-1:0] SGP_RST_ANALOG = 6'h3f;
    localparam logic [SGP_PINS-1:0] SGP_RST_OPEN_DRAIN = 6'h00;
    localparam logic [SGP_PINS-1:0] SGP_RST_SLEW = 6'h3f;

    // drive decision for all pads, one bit per pin
    typedef struct packed {
        logic [SGP_PINS-1:0] out;
        logic [SGP_PINS-1:0] oe;
    } sgp_pad_type;

endpackage

// file: hdl/sgp_sync.sv
// Purpose: multi-stage synchroniser for asynchronous pin levels
// Assumes: each bit is an independent level, no bus coherency needed
// Notes:   only the last stage is visible outside
`timescale 1ns/1ps
module sgp_sync
    import sgp_pkg::*;
#(
    parameter int WIDTH = SGP_PINS
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule // sgp_sync

// file: hdl/sgp_port.sv
// Purpose: six-pin bidirectional port with latch, direction, analog select,
//          open-drain and slew controls behind an APB slave
// Assumes: pin inputs asynchronous to pclk; peripheral controls on pclk
// Notes:   zero-wait APB, read data is captured in the setup cycle
//          pads are registered, so every drive change shows one edge late
//          pin reads lag the pads by the two synchroniser edges
//          unmapped addresses answer with an error and change nothing
`timescale 1ns/1ps

// How it works
// - six independent pins, each with direction, latch and read path
// - direction one turns the driver off; zero drives the latch value
// - a write to the pin-value register updates the output latch
// - latch register reads the latch; pin-value register reads the pins
// - pin-value write stores the written bits if lane zero is set, else the current pin levels
// - latch holds the latest value from either register write
// - analog select disables that pin's digital input buffer
// - pins in analog mode read as zero
// - direction still gates the driver of an analog input pin
// - after reset every pin is an input with its driver off
// - digital outputs keep driving a pin in analog mode
// - an enabled analog output forces the digital driver off
// - an enabled peripheral replaces the latch; pin stays readable
// - per-pin open-drain bit makes the driver sink only
// - two-wire serial ownership forces open-drain by itself on a pin whose peripheral is enabled
// - per-pin slew bit limits drive edges when set
// - every reset sets all direction bits to input
// - analog select resets to analog; software clears it for digital use
module sgp_port
    import sgp_pkg::*;
#(
    parameter int PINS = SGP_PINS
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SGP_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // peripheral side, one bit per pin
    input wire logic [PINS-1:0] periph_en,
    input wire logic [PINS-1:0] periph_out,
    input wire logic [PINS-1:0] twowire_own,
    input wire logic [PINS-1:0] analog_out_en,
    output logic [PINS-1:0] periph_in,
    // pads
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe,
    output logic [PINS-1:0] pin_slew_limit,
    output logic [PINS-1:0] pin_input_buf_off
);

    logic [PINS-1:0] lat_q;
    logic [PINS-1:0] lat_d;
    logic [PINS-1:0] dir_q;
    logic [PINS-1:0] ana_q;
    logic [PINS-1:0] od_q;
    logic [PINS-1:0] slew_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [PINS-1:0] pin_sync;
    logic [PINS-1:0] pin_read;
    logic [PINS-1:0] drv_data;
    logic [PINS-1:0] drv_en;
    logic [PINS-1:0] od_eff;
    sgp_pad_type pad_d;
    sgp_pad_type pad_q;

    // pin levels cross into pclk through two flops before any use
    // a pin read therefore trails the pad by two edges plus the capture edge
    sgp_sync #(
        .WIDTH(PINS)
    ) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // address decode; access phase takes effect, setup phase captures read data
    // decode is full on all address bits, so no register has an alias
    wire setup_ph = psel && !penable;
    wire access_wr = psel && penable && pwrite;
    wire hit_pin = (paddr == SGP_OFF_PIN_VALUE);
    wire hit_lat = (paddr == SGP_OFF_OUTPUT_LATCH);
    wire hit_dir = (paddr == SGP_OFF_DIRECTION);
    wire hit_ana = (paddr == SGP_OFF_ANALOG_SELECT);
    wire hit_od = (paddr == SGP_OFF_OPEN_DRAIN);
    wire hit_slew = (paddr == SGP_OFF_SLEW_LIMIT);
    wire hit_any = hit_pin | hit_lat | hit_dir | hit_ana | hit_od | hit_slew;
    wire lane0 = pstrb[0];
    wire wr_pin = access_wr && hit_pin;
    wire wr_lat = access_wr && hit_lat && lane0;
    wire wr_dir = access_wr && hit_dir && lane0;
    wire wr_ana = access_wr && hit_ana && lane0;
    wire wr_od = access_wr && hit_od && lane0;
    wire wr_slew = access_wr && hit_slew && lane0;

    // write data narrowed once; lanes above zero carry no pin bits
    wire [PINS-1:0] wr_bits = pwdata[PINS-1:0];

    // zero wait states; unmapped addresses answer with an error
    // a write to an unmapped address is dropped, a read returns zero
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_any;
    assign prdata = rdata_q;

    // analog pins read zero because their input buffer is off
    // peripherals see the same masked levels that software reads
    assign pin_input_buf_off = ana_q;
    assign pin_read = pin_sync & ~ana_q;
    assign periph_in = pin_read;

    // pin-value write is read-modify-write: an unaddressed byte keeps the
    // pin levels, which can flip latch bits of pins driven by others
    // a write with lane zero set stores the written bits as given
    assign lat_d = wr_pin ? (lane0 ? pwdata[PINS-1:0] : pin_read) :
                   wr_lat ? pwdata[PINS-1:0] : lat_q;

    // read mux for the setup cycle; upper bits read as zero
    // a write cycle leaves the captured word at zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (setup_ph && !pwrite) begin
            case (1'b1)
                hit_pin: rdata_d[PINS-1:0] = pin_read;
                hit_lat: rdata_d[PINS-1:0] = lat_q;
                hit_dir: rdata_d[PINS-1:0] = dir_q;
                hit_ana: rdata_d[PINS-1:0] = ana_q;
                hit_od: rdata_d[PINS-1:0] = od_q;
                hit_slew: rdata_d[PINS-1:0] = slew_q;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // control registers; all reset values make pins safe inputs
    // the latch reloads every edge from lat_d, which holds it when idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_q <= SGP_RST_LATCH;
            dir_q <= SGP_RST_DIRECTION;
            ana_q <= SGP_RST_ANALOG;
            od_q <= SGP_RST_OPEN_DRAIN;
            slew_q <= SGP_RST_SLEW;
        end else begin
            lat_q <= lat_d;
            if (wr_dir) dir_q <= pwdata[PINS-1:0];
            if (wr_ana) ana_q <= pwdata[PINS-1:0];
            if (wr_od) od_q <= pwdata[PINS-1:0];
            if (wr_slew) slew_q <= pwdata[PINS-1:0];
        end
    end

    // read data register holds through the access phase
    // capturing at setup keeps the read path off the access edge timing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (setup_ph) begin
            rdata_q <= rdata_d;
        end
    end

    // per-pin drive priority: analog output, then peripheral, then latch
    // the analog output wins so its pad never fights a digital driver
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_pin
            // analog select is not consulted here, so digital drive survives it
            assign drv_data[gi] = periph_en[gi] ? periph_out[gi] : lat_q[gi];
            // direction gates every digital driver, analog inputs included
            assign drv_en[gi] = !dir_q[gi] && !analog_out_en[gi];
            // the two-wire owner forces open drain with no register write
            assign od_eff[gi] = od_q[gi] || (periph_en[gi] && twowire_own[gi]);
            // open drain only enables the driver to pull low
            assign pad_d.out[gi] = drv_data[gi];
            assign pad_d.oe[gi] = drv_en[gi] && !(od_eff[gi] && drv_data[gi]);
        end
    endgenerate

    // pads come from flops to keep glitches off the pins
    // the cost is one edge of latency on every drive change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_q <= '0;
        end else begin
            pad_q <= pad_d;
        end
    end

    // the pad outputs are the flop outputs, nothing in between
    assign pin_out = pad_q.out;
    assign pin_oe = pad_q.oe;
    assign pin_slew_limit = slew_q;

    // checks; pad outputs are compared one edge after their cause
    // because the drive decision passes through pad_q
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_dir_blocks_drive: assert property (
        1'b1 |=> ((pin_oe & $past(dir_q)) == '0))
        else $error("input pin has its driver on");

    a_latch_drives_pin: assert property (
        1'b1 |=> (((pin_out ^ $past(lat_q)) & pin_oe & ~$past(periph_en)) == '0))
        else $error("driven pin differs from latch");

    a_pin_write_latch: assert property (
        (wr_pin && lane0) |=> (lat_q == $past(wr_bits)))
        else $error("pin-value write missed latch");

    a_pin_rmw_keep: assert property (
        (wr_pin && !lane0) |=> (lat_q == $past(pin_read)))
        else $error("read-modify-write did not take pin levels");

    a_latch_write: assert property (
        wr_lat |=> (lat_q == $past(wr_bits))
            ##1 (lat_q == $past(lat_q) || $past(wr_lat) || $past(wr_pin)))
        else $error("latch write lost");

    a_analog_reads_zero: assert property (
        (setup_ph && !pwrite && hit_pin) |=> ((prdata[PINS-1:0] & $past(ana_q)) == '0))
        else $error("analog pin read nonzero");

    a_latch_readback: assert property (
        (setup_ph && !pwrite && hit_lat) |=> (prdata[PINS-1:0] == $past(lat_q)) ##1 1'b1)
        else $error("latch read mismatch");

    a_analog_out_hiz: assert property (
        1'b1 |=> ((pin_oe & $past(analog_out_en)) == '0))
        else $error("analog output pin still driven");

    a_open_drain_low: assert property (
        1'b1 |=> ((pin_oe & pin_out & $past(od_q)) == '0))
        else $error("open-drain pin driven high");

    a_twowire_od: assert property (
        1'b1 |=> ((pin_oe & pin_out & $past(periph_en) & $past(twowire_own)) == '0))
        else $error("two-wire pin driven high");

    a_buf_off_analog: assert property (
        wr_ana |=> (pin_input_buf_off == $past(wr_bits)))
        else $error("input buffer not following analog select");

    a_dir_update: assert property (
        wr_dir |=> (dir_q == $past(wr_bits)))
        else $error("direction write late or lost");

    a_slew_follow: assert property (
        wr_slew |=> (pin_slew_limit == $past(wr_bits)))
        else $error("slew control not updated");

    a_od_update: assert property (
        wr_od |=> (od_q == $past(wr_bits)))
        else $error("open-drain write late or lost");

    // registers move only on their own writes
    a_latch_hold: assert property (
        !(wr_lat || wr_pin) |=> (lat_q == $past(lat_q)))
        else $error("latch changed without a write");

    a_dir_hold: assert property (
        !wr_dir |=> (dir_q == $past(dir_q)))
        else $error("direction changed without a write");

    a_unmapped_safe: assert property (
        (access_wr && !hit_any) |=> (lat_q == $past(lat_q) && dir_q == $past(dir_q)))
        else $error("unmapped write changed a register");

    // drive and readback as seen from outside
    a_periph_drives_pin: assert property (
        1'b1 |=> (((pin_out ^ $past(periph_out)) & pin_oe & $past(periph_en)) == '0))
        else $error("driven pin differs from peripheral data");

    a_digital_in_analog: assert property (
        1'b1 |=> ((~pin_oe & ~$past(dir_q) & ~$past(analog_out_en) & ~$past(od_q)
            & ~$past(twowire_own)) == '0))
        else $error("push-pull output pin not driven");

    a_pin_readback: assert property (
        (setup_ph && !pwrite && hit_pin) |=> (prdata[PINS-1:0] == $past(pin_read)))
        else $error("pin-value read mismatch");

    a_unmapped_read_zero: assert property (
        (setup_ph && !pwrite && !hit_any) |=> (prdata == 32'h0000_0000))
        else $error("unmapped read returned data");

    // scenarios worth seeing at least once
    c_pin_driven: cover property ((dir_q != '0) ##1 (pin_oe != '0));
    c_rmw_write: cover property (wr_pin && !lane0);
    c_periph_drive: cover property ((periph_en & ~dir_q) != '0);
    c_unmapped: cover property (pslverr);
    c_analog_out: cover property ((analog_out_en & ~dir_q) != '0);

endmodule // sgp_port

// file: tb/sgp_pad_model.sv
// Purpose: board side of the six pads, an external source plus pull-ups
// Assumes: where the port and the external source both drive a pin, the port wins
// Notes:   a released pin with no external source goes to the pull-up level, never to its last value
`timescale 1ns/1ps
module sgp_pad_model
    import sgp_pkg::*;
(
    // drive from the port
    input wire sgp_pad_type pad,
    // external source per pin
    input wire logic [SGP_PINS-1:0] ext_en,
    input wire logic [SGP_PINS-1:0] ext_val,
    // level at the pins
    output logic [SGP_PINS-1:0] pin_in
);
    // open drain needs the pull-up so a released high reads as one
    wire [SGP_PINS-1:0] ext_level = (ext_en & ext_val) | ~ext_en;
    assign pin_in = (pad.oe & pad.out) | (~pad.oe & ext_level);
endmodule // sgp_pad_model

// file: tb/sgp_port_test.sv
// Purpose: self-checking bench for the six-pin port
// Assumes: zero-wait APB slave, two-flop pin synchroniser
// Notes:   waits of a few cycles cover the pad and synchroniser latency
`timescale 1ns/1ps
module sgp_port_test
    import sgp_pkg::*;
;
    typedef struct packed {
        logic [SGP_AW-1:0] addr;
        logic [31:0] data;
        logic [31:0] exp;
        logic err;
    } sgp_row_type;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [SGP_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [SGP_PINS-1:0] periph_en, periph_out, twowire_own, analog_out_en, periph_in;
    logic [SGP_PINS-1:0] pin_in, pin_out, pin_oe, pin_slew_limit, pin_input_buf_off;
    logic [SGP_PINS-1:0] ext_en, ext_val;
    sgp_pad_type pad;
    int error_cnt, n_tests;
    sgp_row_type rst_rows [6] = '{'{SGP_OFF_OUTPUT_LATCH, 0, 32'h00, 0},
        '{SGP_OFF_DIRECTION, 0, 32'h3f, 0}, '{SGP_OFF_ANALOG_SELECT, 0, 32'h3f, 0},
        '{SGP_OFF_OPEN_DRAIN, 0, 32'h00, 0}, '{SGP_OFF_SLEW_LIMIT, 0, 32'h3f, 0},
        '{SGP_OFF_PIN_VALUE, 0, 32'h00, 0}};
    sgp_row_type rows [6] = '{'{SGP_OFF_OUTPUT_LATCH, 32'hffff_ffea, 32'h2a, 0},
        '{SGP_OFF_DIRECTION, 32'h15, 32'h15, 0}, '{SGP_OFF_ANALOG_SELECT, 32'h00, 32'h00, 0},
        '{SGP_OFF_OPEN_DRAIN, 32'h3c, 32'h3c, 0}, '{SGP_OFF_SLEW_LIMIT, 32'h05, 32'h05, 0},
        '{8'h18, 32'h3f, 32'h00, 1}};

    assign pad = {pin_out, pin_oe};

    sgp_port sgp_port_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periph_en(periph_en), .periph_out(periph_out),
        .twowire_own(twowire_own), .analog_out_en(analog_out_en), .periph_in(periph_in),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_slew_limit(pin_slew_limit),
        .pin_input_buf_off(pin_input_buf_off));

    sgp_pad_model sgp_pad_model_i (.pad(pad), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));

    // clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one full transfer; the idle edge first keeps back-to-back calls legal
    task automatic apb(input logic wr, input logic [SGP_AW-1:0] a, input logic [31:0] d,
            input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // expected pad enable worked out from the priority order
    function automatic logic [31:0] exp_oe(input logic [5:0] dir, input logic [5:0] lat,
            input logic [5:0] od);
        logic [5:0] o;
        o = (periph_en & periph_out) | (~periph_en & lat);
        return {26'h0, ~dir & ~analog_out_en & ~((od | (periph_en & twowire_own)) & o)};
    endfunction

    // watchdog, far beyond the roughly 125 cycles the run needs
    initial begin
        tick(20000);
        error_cnt++;
        conclude();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {periph_en, periph_out, twowire_own, analog_out_en} = '0;
        ext_en = 6'h3f;
        ext_val = 6'h3f;
        tick(6);
        presetn <= 1'b1;
        tick(1);
        chk(pin_oe, 0);
        chk(pin_input_buf_off, 6'h3f);
        chk(pin_slew_limit, 6'h3f);
        foreach (rst_rows[i]) begin
            apb(0, rst_rows[i].addr, 0, 4'h1);
            chk(rd, rst_rows[i].exp);
        end
        $display("reset values done");
        foreach (rows[i]) begin
            apb(1, rows[i].addr, rows[i].data, 4'h1);
            apb(0, rows[i].addr, 0, 4'h1);
            chk(rd, rows[i].exp);
            chk(e, rows[i].err);
        end
        chk(pin_slew_limit, 6'h05);
        chk(pin_input_buf_off, 6'h00);
        $display("register rows done");
        apb(1, SGP_OFF_OPEN_DRAIN, 0, 4'h1);
        apb(1, SGP_OFF_DIRECTION, 32'h30, 4'h1);
        ext_en <= 6'h30;
        ext_val <= 6'h10;
        tick(4);
        chk(pin_oe, exp_oe(6'h30, 6'h2a, 6'h0));
        chk(pin_out & pin_oe, 6'h0a);
        apb(0, SGP_OFF_PIN_VALUE, 0, 4'h1);
        chk(rd, 32'h1a);
        apb(1, SGP_OFF_PIN_VALUE, 32'h05, 4'h1);
        apb(0, SGP_OFF_OUTPUT_LATCH, 0, 4'h1);
        chk(rd, 32'h05);
        apb(1, SGP_OFF_OUTPUT_LATCH, 32'h2a, 4'h1);
        tick(4);
        apb(1, SGP_OFF_PIN_VALUE, 32'h3f, 4'h0);
        apb(0, SGP_OFF_OUTPUT_LATCH, 0, 4'h1);
        chk(rd, 32'h1a);
        $display("latch and pin value done");
        apb(1, SGP_OFF_ANALOG_SELECT, 32'h02, 4'h1);
        tick(4);
        apb(0, SGP_OFF_PIN_VALUE, 0, 4'h1);
        chk(rd, 32'h18);
        chk(pin_input_buf_off, 6'h02);
        chk(periph_in & 6'h02, 0);
        chk(pin_oe, exp_oe(6'h30, 6'h1a, 6'h0));
        apb(1, SGP_OFF_OPEN_DRAIN, 32'h02, 4'h1);
        tick(3);
        chk(pin_oe, exp_oe(6'h30, 6'h1a, 6'h02));
        analog_out_en <= 6'h04;
        periph_en <= 6'h08;
        tick(3);
        chk(pin_oe, exp_oe(6'h30, 6'h1a, 6'h02));
        chk(pin_out & pin_oe, 6'h00);
        twowire_own <= 6'h08;
        periph_out <= 6'h08;
        tick(3);
        chk(pin_oe, exp_oe(6'h30, 6'h1a, 6'h02));
        $display("priority and drive done");
        {periph_en, periph_out, twowire_own, analog_out_en} <= '0;
        presetn <= 1'b0;
        tick(2);
        chk(pin_oe, 0);
        presetn <= 1'b1;
        apb(0, SGP_OFF_DIRECTION, 0, 4'h1);
        chk(rd, 32'h3f);
        apb(0, SGP_OFF_OUTPUT_LATCH, 0, 4'h1);
        chk(rd, 32'h00);
        $display("second reset done");
        conclude();
    end
endmodule // sgp_port_test
